// ---- core/eisn_consts.svh ----
`ifndef EISN_CONSTS_SVH
`define EISN_CONSTS_SVH

// ==========================================================
// register word indices (byte address = 4 * index)
`define EISN_IDX_SNSC   16'hF1DE
`define EISN_IDX_NODE   16'h0100
`define EISN_IDX_CH_CTL 16'h0200
`define EISN_IDX_CH_CAP 16'h0300
`define EISN_IDX_A_CTL  16'h0400
`define EISN_IDX_A_VAL  16'h0401
`define EISN_IDX_B_CTL  16'h0402
`define EISN_IDX_B_VAL  16'h0403
`define EISN_IDX_K_CTL  16'h0404
`define EISN_IDX_K_VAL  16'h0405

// ==========================================================
// shared sub-node bits
`define EISN_SN_CAL_REQ 0
`define EISN_SN_CAL_EN  1
`define EISN_SN_CLK_REQ 2
`define EISN_SN_CLK_EN  3
`define EISN_NODE_LVL   2

// capture channel control fields
`define EISN_CH_MODE 0
`define EISN_CH_REQ  3
`define EISN_CH_EN   4
`define EISN_CH_PEC  5

// auxiliary timer control fields
`define EISN_AUX_ISEL     0
`define EISN_AUX_MODE     3
`define EISN_AUX_REQ      6
`define EISN_AUX_EN       7
`define EISN_AUX_PEC      8
`define EISN_AUX_MODE_CAP 3'h5

// block2 timer control fields
`define EISN_K_EDGE  0
`define EISN_K_CAPEN 2
`define EISN_K_REQ   3
`define EISN_K_EN    4
`define EISN_K_PEC   5

`define EISN_RST_REG 16'h0000

// ==========================================================
// timing: one half_state_time in ps, sample periods in it
`define EISN_CLK_PS  5000
`define EISN_TCL_PS  5000
`define EISN_STD_TCL 16
`define EISN_CAP_TCL 8
`define EISN_NMI_TCL 2
`define EISN_CYC(t) (((t) * `EISN_TCL_PS) / `EISN_CLK_PS)

`endif

// ---- core/eisn_pkg.sv ----
package eisn_pkg;

  typedef enum logic {
    BUS_IDLE,
    BUS_ACK
  } eisn_bus_phase_t;

  typedef struct packed {
    logic        read;
    logic        write;
    logic [15:0] address;
    logic [31:0] writedata;
    logic [3:0]  byteenable;
  } eisn_avmm_req_t;

  typedef struct packed {
    logic [31:0] readdata;
    logic        waitrequest;
  } eisn_avmm_rsp_t;

endpackage : eisn_pkg

// ---- core/eisn_top.sv ----
// Chosen here: register access over Avalon-MM.
`timescale 1ns/1ps
`default_nettype none
`include "eisn_consts.svh"

// What this block does
// [R1] sub-node register keeps separate request flag and enable per source
// [R2] shared node arbitration level comes from the node control register
// [R3] bits 3/2 clock-loss enable/request, bits 1/0 calendar enable/request
// [R4] sub-node request flag reads 1 while its source request is pending
// [R5] sub-node enable 1 passes request to node, 0 blocks it
// [R6] software never writes ones to reserved sub-node bits 15..4
// [R7] pins trigger on rise, fall or both, only in proper mode
// [R8] software sets pin direction to input before use
// [R9] channel mode 001 rise, 010 fall, 011 both sets channel flag
// [R10] selected channel edge latches channel timer into capture register
// [R11] channel flag with enable gives transfer or interrupt request
// [R12] auxiliary pins act as interrupt inputs in timer mode 101
// [R13] auxiliary input select X01 rise, X10 fall, X11 both
// [R14] selected auxiliary edge copies core timer into auxiliary register
// [R15] auxiliary flag with enable gives transfer or interrupt request
// [R16] capture enable 0: capture pin only sets flag, no capture
// [R17] capture/reload register stays usable as reload value
// [R18] capture edge field 01 rise, 10 fall, 11 both
// [R19] capture/reload flag with enable gives interrupt or transfer request
// [R20] non-maskable pin sampled every 2 HALF_STATE_TIME, raises a trap
// [R21] standard pins sampled every 16 HALF_STATE_TIME, capture pin every 8 HALF_STATE_TIME
// [R22] transfer acknowledge clears the source request flag
// [R23] shared node request is OR of enabled sub-node requests
// [R24] edges found by comparing consecutive synchronised samples
module eisn_top #(
  parameter int NUM_CH = 32
) (
  input  wire logic                    ref_clk_in,
  input  wire logic                    rstn_in,
  input  wire logic                    ce_in,
  input  wire eisn_pkg::eisn_avmm_req_t avmm_in,
  output var  eisn_pkg::eisn_avmm_rsp_t avmm_out,
  input  wire logic [NUM_CH-1:0]       channel_pin_in,
  input  wire logic                    aux_timer_a_pin_in,
  input  wire logic                    aux_timer_b_pin_in,
  input  wire logic                    block2_capture_pin_in,
  input  wire logic                    nmi_n_pin_in,
  input  wire logic                    clock_loss_event_in,
  input  wire logic                    calendar_event_in,
  input  wire logic [15:0]             channel_timer_in,
  input  wire logic [15:0]             core_timer_in,
  input  wire logic [15:0]             block2_timer_in,
  input  wire logic [NUM_CH+3:0]       pec_ack_in,
  output logic      [NUM_CH+3:0]       int_req_out,
  output logic      [NUM_CH+3:0]       pec_req_out,
  output logic      [3:0]              shared_node_level_out,
  output logic      [15:0]             capture_reload_out,
  output logic                         trap_req_out
);

  // ==========================================================
  // sizes and sample periods
  localparam int NPIN = NUM_CH + 4;
  localparam int IA   = NUM_CH;
  localparam int IB   = NUM_CH + 1;
  localparam int IK   = NUM_CH + 2;
  localparam int IN   = NUM_CH + 3;

  localparam logic [7:0] STD_LAST = 8'(`EISN_CYC(`EISN_STD_TCL) - 1);
  localparam logic [7:0] CAP_LAST = 8'(`EISN_CYC(`EISN_CAP_TCL) - 1);
  localparam logic [7:0] NMI_LAST = 8'(`EISN_CYC(`EISN_NMI_TCL) - 1);

  typedef struct packed {
    eisn_pkg::eisn_bus_phase_t   phase;
    eisn_pkg::eisn_avmm_rsp_t    rsp;
    logic [3:0]                  snsc;
    logic [15:0]                 node_ctl;
    logic [NUM_CH-1:0][15:0]     ch_ctl;
    logic [NUM_CH-1:0][15:0]     ch_cap;
    logic [15:0]                 a_ctl;
    logic [15:0]                 a_val;
    logic [15:0]                 b_ctl;
    logic [15:0]                 b_val;
    logic [15:0]                 k_ctl;
    logic [15:0]                 k_val;
    logic [NPIN-1:0]             s1;
    logic [NPIN-1:0]             s2;
    logic [NPIN-1:0]             smp;
    logic [7:0]                  cnt_std;
    logic [7:0]                  cnt_cap;
    logic [7:0]                  cnt_nmi;
    logic [NPIN-1:0]             irq;
    logic [NPIN-1:0]             peripheral_event_transfer;
    logic [3:0]                  lvl;
    logic                        trap;
  } eisn_state_t;

  eisn_state_t st;
  eisn_state_t next_st;

  // ==========================================================
  // helpers
  function automatic logic edge_hit(
    input logic [1:0] sel,
    input logic       rise,
    input logic       fall
  );
    // sel[0] picks rising, sel[1] falling; both gives any edge
    edge_hit = (sel[0] & rise) | (sel[1] & fall);
  endfunction : edge_hit

  function automatic logic [15:0] merge16(
    input logic [15:0] old,
    input logic [31:0] wd,
    input logic [3:0]  be
  );
    merge16 = old;
    if (be[0]) begin
      merge16[7:0] = wd[7:0];
    end
    if (be[1]) begin
      merge16[15:8] = wd[15:8];
    end
  endfunction : merge16

  function automatic logic [7:0] count_next(
    input logic [7:0] cnt,
    input logic [7:0] last
  );
    count_next = (cnt >= last) ? 8'h00 : cnt + 8'h01;
  endfunction : count_next

  // ==========================================================
  // next-state logic
  always_comb begin
    logic [NPIN-1:0] pins;
    logic [NPIN-1:0] stb;
    logic [NPIN-1:0] rise;
    logic [NPIN-1:0] fall;
    logic [31:0]     rdata;
    logic [15:0]     wv;
    logic            hit;
    pins  = '0;
    stb   = '0;
    rise  = '0;
    fall  = '0;
    rdata = '0;
    wv    = '0;
    hit   = 1'b0;
    next_st = st;

    // ---- pin synchronisers and sample strobes
    pins = {~nmi_n_pin_in, block2_capture_pin_in, aux_timer_b_pin_in,
            aux_timer_a_pin_in, channel_pin_in};
    next_st.s1 = pins;
    next_st.s2 = st.s1;
    // [R21] sample periods
    next_st.cnt_std = count_next(st.cnt_std, STD_LAST);
    next_st.cnt_cap = count_next(st.cnt_cap, CAP_LAST);
    // [R20] fast nmi sampling
    next_st.cnt_nmi = count_next(st.cnt_nmi, NMI_LAST);
    stb = {st.cnt_nmi == 8'h00, st.cnt_cap == 8'h00,
           {(NUM_CH + 2){st.cnt_std == 8'h00}}};

    // [R24] consecutive sample compare
    rise = stb & st.s2 & ~st.smp;
    fall = stb & ~st.s2 & st.smp;
    next_st.smp = (stb & st.s2) | (~stb & st.smp);

    // ---- register bus, one wait cycle per access
    case (st.phase)
      eisn_pkg::BUS_IDLE: begin
        next_st.rsp.waitrequest = 1'b1;
        if (avmm_in.read || avmm_in.write) begin
          next_st.phase = eisn_pkg::BUS_ACK;
          next_st.rsp.waitrequest = 1'b0;
        end
        if (avmm_in.read) begin
          case (avmm_in.address)
            // [R6] reserved bits read zero
            `EISN_IDX_SNSC: rdata = {28'h0000000, st.snsc};
            `EISN_IDX_NODE: rdata = {16'h0000, st.node_ctl};
            `EISN_IDX_A_CTL: rdata = {16'h0000, st.a_ctl};
            `EISN_IDX_A_VAL: rdata = {16'h0000, st.a_val};
            `EISN_IDX_B_CTL: rdata = {16'h0000, st.b_ctl};
            `EISN_IDX_B_VAL: rdata = {16'h0000, st.b_val};
            `EISN_IDX_K_CTL: rdata = {16'h0000, st.k_ctl};
            `EISN_IDX_K_VAL: rdata = {16'h0000, st.k_val};
            default: begin
              for (int i = 0; i < NUM_CH; i++) begin
                if (avmm_in.address == 16'(`EISN_IDX_CH_CTL + i)) begin
                  rdata = {16'h0000, st.ch_ctl[i]};
                end
                if (avmm_in.address == 16'(`EISN_IDX_CH_CAP + i)) begin
                  rdata = {16'h0000, st.ch_cap[i]};
                end
              end
            end
          endcase
          next_st.rsp.readdata = rdata;
        end
      end
      eisn_pkg::BUS_ACK: begin
        // write lands on the edge the master sees waitrequest low
        next_st.phase = eisn_pkg::BUS_IDLE;
        next_st.rsp.waitrequest = 1'b1;
        if (avmm_in.write) begin
          case (avmm_in.address)
            `EISN_IDX_SNSC: begin
              // [R6] reserved bits dropped on write
              wv = merge16({12'h000, st.snsc}, avmm_in.writedata,
                           avmm_in.byteenable);
              next_st.snsc = wv[3:0];
            end
            `EISN_IDX_NODE: next_st.node_ctl = merge16(st.node_ctl,
                              avmm_in.writedata, avmm_in.byteenable);
            `EISN_IDX_A_CTL: next_st.a_ctl = merge16(st.a_ctl,
                               avmm_in.writedata, avmm_in.byteenable);
            `EISN_IDX_A_VAL: next_st.a_val = merge16(st.a_val,
                               avmm_in.writedata, avmm_in.byteenable);
            `EISN_IDX_B_CTL: next_st.b_ctl = merge16(st.b_ctl,
                               avmm_in.writedata, avmm_in.byteenable);
            `EISN_IDX_B_VAL: next_st.b_val = merge16(st.b_val,
                               avmm_in.writedata, avmm_in.byteenable);
            `EISN_IDX_K_CTL: next_st.k_ctl = merge16(st.k_ctl,
                               avmm_in.writedata, avmm_in.byteenable);
            // [R17] reload value stays software writable
            `EISN_IDX_K_VAL: next_st.k_val = merge16(st.k_val,
                               avmm_in.writedata, avmm_in.byteenable);
            default: begin
              for (int i = 0; i < NUM_CH; i++) begin
                if (avmm_in.address == 16'(`EISN_IDX_CH_CTL + i)) begin
                  next_st.ch_ctl[i] = merge16(st.ch_ctl[i],
                    avmm_in.writedata, avmm_in.byteenable);
                end
                if (avmm_in.address == 16'(`EISN_IDX_CH_CAP + i)) begin
                  next_st.ch_cap[i] = merge16(st.ch_cap[i],
                    avmm_in.writedata, avmm_in.byteenable);
                end
              end
            end
          endcase
        end
      end
      default: begin
        next_st.phase = eisn_pkg::BUS_IDLE;
        next_st.rsp.waitrequest = 1'b1;
      end
    endcase

    // ---- transfer acknowledge clears, applied before new edges
    // [R22] acknowledge clears flag
    for (int i = 0; i < NUM_CH; i++) begin
      if (pec_ack_in[i]) begin
        next_st.ch_ctl[i][`EISN_CH_REQ] = 1'b0;
      end
    end
    if (pec_ack_in[IA]) begin
      next_st.a_ctl[`EISN_AUX_REQ] = 1'b0;
    end
    if (pec_ack_in[IB]) begin
      next_st.b_ctl[`EISN_AUX_REQ] = 1'b0;
    end
    if (pec_ack_in[IK]) begin
      next_st.k_ctl[`EISN_K_REQ] = 1'b0;
    end

    // ---- capture channels; hardware set wins over any clear
    for (int i = 0; i < NUM_CH; i++) begin
      // [R7] only capture modes 001..011 react
      // [R9] channel edge select
      hit = (st.ch_ctl[i][`EISN_CH_MODE+2] == 1'b0) &&
            edge_hit(st.ch_ctl[i][`EISN_CH_MODE+:2], rise[i], fall[i]);
      if (hit) begin
        next_st.ch_ctl[i][`EISN_CH_REQ] = 1'b1;
        // [R10] latch timer, running or not
        next_st.ch_cap[i] = channel_timer_in;
      end
    end

    // ---- auxiliary timers
    // [R12] capture mode 101 only
    // [R13] low two select bits choose edge
    hit = (st.a_ctl[`EISN_AUX_MODE+:3] == `EISN_AUX_MODE_CAP) &&
          edge_hit(st.a_ctl[`EISN_AUX_ISEL+:2], rise[IA], fall[IA]);
    if (hit) begin
      next_st.a_ctl[`EISN_AUX_REQ] = 1'b1;
      // [R14] copy core timer
      next_st.a_val = core_timer_in;
    end
    hit = (st.b_ctl[`EISN_AUX_MODE+:3] == `EISN_AUX_MODE_CAP) &&
          edge_hit(st.b_ctl[`EISN_AUX_ISEL+:2], rise[IB], fall[IB]);
    if (hit) begin
      next_st.b_ctl[`EISN_AUX_REQ] = 1'b1;
      // [R14] copy core timer
      next_st.b_val = core_timer_in;
    end

    // ---- block2 capture pin
    // [R18] edge field select
    hit = edge_hit(st.k_ctl[`EISN_K_EDGE+:2], rise[IK], fall[IK]);
    if (hit) begin
      next_st.k_ctl[`EISN_K_REQ] = 1'b1;
      // [R16] capture only when enabled
      if (st.k_ctl[`EISN_K_CAPEN]) begin
        next_st.k_val = block2_timer_in;
      end
    end

    // ---- shared sub-node sources, on-chip pulses, no sync
    // [R3] clock-loss on 3/2, calendar on 1/0
    // [R4] pending request sets flag
    if (clock_loss_event_in) begin
      next_st.snsc[`EISN_SN_CLK_REQ] = 1'b1;
    end
    if (calendar_event_in) begin
      next_st.snsc[`EISN_SN_CAL_REQ] = 1'b1;
    end

    // ---- request outputs follow the new flags
    for (int i = 0; i < NUM_CH; i++) begin
      // [R11] channel routing
      next_st.irq[i] = next_st.ch_ctl[i][`EISN_CH_REQ] &
                       next_st.ch_ctl[i][`EISN_CH_EN] &
                       ~next_st.ch_ctl[i][`EISN_CH_PEC];
      next_st.peripheral_event_transfer[i] = next_st.ch_ctl[i][`EISN_CH_REQ] &
                       next_st.ch_ctl[i][`EISN_CH_EN] &
                       next_st.ch_ctl[i][`EISN_CH_PEC];
    end
    // [R15] auxiliary routing
    next_st.irq[IA] = next_st.a_ctl[`EISN_AUX_REQ] &
                      next_st.a_ctl[`EISN_AUX_EN] & ~next_st.a_ctl[`EISN_AUX_PEC];
    next_st.peripheral_event_transfer[IA] = next_st.a_ctl[`EISN_AUX_REQ] &
                      next_st.a_ctl[`EISN_AUX_EN] & next_st.a_ctl[`EISN_AUX_PEC];
    next_st.irq[IB] = next_st.b_ctl[`EISN_AUX_REQ] &
                      next_st.b_ctl[`EISN_AUX_EN] & ~next_st.b_ctl[`EISN_AUX_PEC];
    next_st.peripheral_event_transfer[IB] = next_st.b_ctl[`EISN_AUX_REQ] &
                      next_st.b_ctl[`EISN_AUX_EN] & next_st.b_ctl[`EISN_AUX_PEC];
    // [R19] capture/reload routing
    next_st.irq[IK] = next_st.k_ctl[`EISN_K_REQ] &
                      next_st.k_ctl[`EISN_K_EN] & ~next_st.k_ctl[`EISN_K_PEC];
    next_st.peripheral_event_transfer[IK] = next_st.k_ctl[`EISN_K_REQ] &
                      next_st.k_ctl[`EISN_K_EN] & next_st.k_ctl[`EISN_K_PEC];
    // [R1] independent flag and enable pairs
    // [R5] enable gates each source
    // [R23] shared node is an OR
    next_st.irq[IN] = (next_st.snsc[`EISN_SN_CLK_REQ] &
                       next_st.snsc[`EISN_SN_CLK_EN]) |
                      (next_st.snsc[`EISN_SN_CAL_REQ] &
                       next_st.snsc[`EISN_SN_CAL_EN]);
    // the shared node is serviced by interrupt only
    next_st.peripheral_event_transfer[IN] = 1'b0;
    // [R2] level from node control
    next_st.lvl = next_st.node_ctl[`EISN_NODE_LVL+:4];

    // [R20] nmi falling pin edge traps
    next_st.trap = rise[IN];
  end

  // ==========================================================
  // state register
  always_ff @(posedge ref_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      st <= '0;
      st.rsp.waitrequest <= 1'b1;
    end else if (ce_in) begin
      st <= next_st;
    end
  end

  // ==========================================================
  // outputs straight from the state register
  assign avmm_out              = st.rsp;
  assign int_req_out           = st.irq;
  assign pec_req_out           = st.peripheral_event_transfer;
  assign shared_node_level_out = st.lvl;
  // [R17] reload value for the block2 timer
  assign capture_reload_out    = st.k_val;
  assign trap_req_out          = st.trap;

endmodule : eisn_top

`default_nettype wire

// ---- bench/eisn_top_assertions.sv ----
`timescale 1ns/1ps
`default_nettype none
module eisn_top_assertions #(
  parameter int NUM_CH = 4
) (
  input wire logic                     ref_clk_in,
  input wire logic                     rstn_in,
  input wire logic                     ce_in,
  input wire eisn_pkg::eisn_avmm_req_t avmm_in,
  input wire eisn_pkg::eisn_avmm_rsp_t avmm_out,
  input wire logic [NUM_CH-1:0]        channel_pin_in,
  input wire logic                     nmi_n_pin_in,
  input wire logic [NUM_CH+3:0]        pec_ack_in,
  input wire logic [NUM_CH+3:0]        int_req_out,
  input wire logic [NUM_CH+3:0]        pec_req_out,
  input wire logic [3:0]               shared_node_level_out,
  input wire logic                     trap_req_out
);
  default clocking @(posedge ref_clk_in); endclocking
  default disable iff (!rstn_in);
  logic [5:0] quiet;
  // ====
  // cycles since channel 0 pin last changed or the bus last wrote; saturates so it never wraps
  always_ff @(posedge ref_clk_in or negedge rstn_in) begin
    if (!rstn_in) quiet <= 6'h00;
    else if (avmm_in.write || $changed(channel_pin_in[0])) quiet <= 6'h00;
    else if (quiet != 6'h3F) quiet <= quiet + 6'h01;
  end
  // ====
  wait_once_a: assert property (
    ce_in && (avmm_in.read || avmm_in.write) && avmm_out.waitrequest |=> !avmm_out.waitrequest)
    else $error("bus answer late");
  ack_single_a: assert property (!avmm_out.waitrequest |=> avmm_out.waitrequest)
    else $error("bus answer too long");
  trap_pulse_a: assert property (trap_req_out |=> !trap_req_out)
    else $error("trap longer than one cycle");
  trap_cause_a: assert property (trap_req_out |-> !$past(nmi_n_pin_in, 3))
    else $error("trap without low nmi pin");
  node_nopec_a: assert property (pec_req_out[NUM_CH+3] == 1'b0)
    else $error("shared node issued transfer");
  req_split_a: assert property ((int_req_out & pec_req_out) == '0)
    else $error("interrupt and transfer together");
  ack_clears_a: assert property (
    pec_ack_in[NUM_CH+2] && pec_req_out[NUM_CH+2] |-> ##2 !pec_req_out[NUM_CH+2])
    else $error("transfer request kept after ack");
  chan_cause_a: assert property ($rose(int_req_out[0]) |-> quiet < 6'h18)
    else $error("channel request without edge");
  level_write_a: assert property (
    $changed(shared_node_level_out) |-> $past(avmm_in.write) || $past(avmm_in.write, 2))
    else $error("level moved without write");
  cover property (trap_req_out);
  cover property (pec_req_out[NUM_CH+2]);
  cover property (int_req_out[NUM_CH+3]);
endmodule : eisn_top_assertions
bind eisn_top eisn_top_assertions #(.NUM_CH(NUM_CH)) eisn_top_assertions_inst (
  .ref_clk_in(ref_clk_in), .rstn_in(rstn_in), .ce_in(ce_in), .avmm_in(avmm_in),
  .avmm_out(avmm_out), .channel_pin_in(channel_pin_in), .nmi_n_pin_in(nmi_n_pin_in),
  .pec_ack_in(pec_ack_in), .int_req_out(int_req_out), .pec_req_out(pec_req_out),
  .shared_node_level_out(shared_node_level_out), .trap_req_out(trap_req_out));
`default_nettype wire

// ---- bench/eisn_pin_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module eisn_pin_model #(
  parameter int NUM_CH = 4
) (
  input  wire logic              clk_in,
  input  wire logic [NUM_CH+3:0] want_in,
  input  wire logic [3:0]        lag_in,
  output logic      [NUM_CH+3:0] pin_out
);
  logic [3:0] wait_cnt;
  initial begin
    pin_out = '0;
    pin_out[NUM_CH+3] = 1'b1;
    wait_cnt = 4'h0;
  end
  // ====
  // pins driven as device inputs only
  // a level lands after a lag and then holds, so slow sampling still sees it
  always @(posedge clk_in) begin
    if (want_in == pin_out) wait_cnt <= 4'h0;
    else if (wait_cnt < lag_in) wait_cnt <= wait_cnt + 4'h1;
    else begin
      pin_out  <= want_in;
      wait_cnt <= 4'h0;
    end
  end
endmodule : eisn_pin_model
`default_nettype wire

// ---- bench/eisn_tb_top.sv ----
`timescale 1ns/1ps
`default_nettype none
module eisn_tb_top;
  localparam int NC = 4;
  logic                     ref_clk_in = 1'b0;
  logic                     rstn_in;
  eisn_pkg::eisn_avmm_req_t req;
  eisn_pkg::eisn_avmm_rsp_t rsp;
  logic [NC+3:0]            want;
  logic [NC+3:0]            pins;
  logic [3:0]               lag;
  logic                     ev_clk;
  logic                     ev_cal;
  logic [15:0]              tmr;
  logic [NC+3:0]            ack;
  logic [NC+3:0]            int_req;
  logic [NC+3:0]            pec_req;
  logic [3:0]               lvl;
  logic [15:0]              capture_reload_register;
  logic                     trap;
  logic [15:0]              v;
  logic [15:0]              rl;
  logic                     hit;
  logic [15:0]              exp_q[$];
  logic [15:0]              sn_v[5] = '{16'h000C, 16'h000A, 16'h0001, 16'h0003, 16'h0000};
  logic                     sn_n[5] = '{1'h1, 1'h0, 1'h0, 1'h1, 1'h0};
  logic [15:0]              ctl_a[4] = '{16'h0200, 16'h0400, 16'h0402, 16'h0404};
  logic [15:0]              base[4] = '{16'h0010, 16'h00A8, 16'h00A8, 16'h0010};
  logic [15:0]              val_a[4] = '{16'h0300, 16'h0401, 16'h0403, 16'h0405};
  int                       src[4] = '{0, NC, NC + 1, NC + 2};
  int                       failures = 0;
  int                       n_tests = 0;
  int                       traps = 0;
  int                       seed = 76;

  always #2.5 ref_clk_in = ~ref_clk_in;

  eisn_top #(.NUM_CH(NC)) eisn_top_inst (
    .ref_clk_in(ref_clk_in), .rstn_in(rstn_in), .ce_in(1'b1), .avmm_in(req), .avmm_out(rsp),
    .channel_pin_in(pins[NC-1:0]), .aux_timer_a_pin_in(pins[NC]), .aux_timer_b_pin_in(pins[NC+1]),
    .block2_capture_pin_in(pins[NC+2]), .nmi_n_pin_in(pins[NC+3]), .clock_loss_event_in(ev_clk),
    .calendar_event_in(ev_cal), .channel_timer_in(tmr), .core_timer_in(~tmr), .block2_timer_in(tmr),
    .pec_ack_in(ack), .int_req_out(int_req), .pec_req_out(pec_req), .shared_node_level_out(lvl),
    .capture_reload_out(capture_reload_register), .trap_req_out(trap));

  eisn_pin_model #(.NUM_CH(NC)) eisn_pin_model_inst (
    .clk_in(ref_clk_in), .want_in(want), .lag_in(lag), .pin_out(pins));

  // ====
  task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp) begin
      failures++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : wrap_up

  // request held until the rising edge that sees waitrequest low, released right after it;
  // a slave that never answers is left to the watchdog
  task automatic bus(input logic wr, input logic [15:0] a, input logic [15:0] d);
    @(posedge ref_clk_in);
    req <= '{read: !wr, write: wr, address: a, writedata: {16'h0000, d}, byteenable: 4'hF};
    do begin
      @(posedge ref_clk_in);
    end while (rsp.waitrequest !== 1'b0);
    req <= '0;
  endtask : bus

  task automatic rd(input logic [15:0] a, input logic [15:0] e);
    exp_q.push_back(e);
    bus(1'b0, a, 16'h0000);
  endtask : rd

  // 40 cycles covers lag, two sync stages and the slowest sample period
  task automatic pin(input int b, input logic lv);
    @(posedge ref_clk_in);
    lag <= 4'($random(seed) & 7);
    want[b] <= lv;
    repeat (40) @(posedge ref_clk_in);
  endtask : pin

  // read data taken at the same rising edge the master sees waitrequest low
  always @(posedge ref_clk_in) begin
    if (req.read && rsp.waitrequest === 1'b0) chk("readdata", rsp.readdata[15:0], exp_q.pop_front());
    if (trap === 1'b1) traps++;
  end

  initial begin
    repeat (20000) @(posedge ref_clk_in);
    failures++;
    wrap_up();
  end

  initial begin
    rstn_in = 1'b0;
    req = '0;
    want = '0;
    want[NC+3] = 1'b1;
    lag = 4'h0;
    ev_clk = 1'b0;
    ev_cal = 1'b0;
    tmr = 16'h0000;
    ack = '0;
    repeat (8) @(posedge ref_clk_in);
    rstn_in <= 1'b1;
    rd(16'hF1DE, 16'h0000);
    rd(16'h0777, 16'h0000);
    @(posedge ref_clk_in);
    ev_clk <= 1'b1;
    ev_cal <= 1'b1;
    @(posedge ref_clk_in);
    ev_clk <= 1'b0;
    ev_cal <= 1'b0;
    rd(16'hF1DE, 16'h0005);
    chk("node_req", int_req[NC+3], 1'h0);
    for (int i = 0; i < 5; i++) begin
      wr_sn : bus(1'b1, 16'hF1DE, sn_v[i]);
      repeat (3) @(posedge ref_clk_in);
      chk("node_req", int_req[NC+3], sn_n[i]);
      rd(16'hF1DE, sn_v[i]);
    end
    bus(1'b1, 16'h0100, 16'h0028);
    repeat (3) @(posedge ref_clk_in);
    chk("level", lvl, 4'hA);
    rl = 16'($random(seed));
    bus(1'b1, 16'h0405, rl);
    for (int u = 0; u < 4; u++) begin
      for (int m = 0; m < 4; m++) begin
        for (int e = 0; e < 2; e++) begin
          v = 16'($random(seed));
          tmr <= v;
          bus(1'b1, ctl_a[u], base[u] | 16'(m));
          hit = (e == 0) ? m[0] : m[1];
          pin(src[u], e == 0);
          chk("edge_req", int_req[src[u]], hit);
          if (u < 3 && hit) rd(val_a[u], (u == 0) ? v : ~v);
          if (u == 3) chk("reload", capture_reload_register, rl);
        end
      end
    end
    bus(1'b1, 16'h0400, 16'h0081);
    pin(NC, 1'b1);
    chk("aux_mode", int_req[NC], 1'h0);
    bus(1'b1, 16'h0404, 16'h0031);
    pin(NC + 2, 1'b1);
    chk("pec_req", pec_req[NC+2], 1'h1);
    chk("int_req", int_req[NC+2], 1'h0);
    rd(16'h0404, 16'h0039);
    @(posedge ref_clk_in);
    ack[NC+2] <= 1'b1;
    @(posedge ref_clk_in);
    ack <= '0;
    repeat (3) @(posedge ref_clk_in);
    chk("pec_clr", pec_req[NC+2], 1'h0);
    rd(16'h0404, 16'h0031);
    pin(NC + 3, 1'b0);
    chk("traps", 16'(traps), 16'h0001);
    pin(NC + 3, 1'b1);
    chk("traps", 16'(traps), 16'h0001);
    wrap_up();
  end
endmodule : eisn_tb_top
`default_nettype wire
